// ### safe_speed_limit_monitor_test.sv
// safe_speed_limit_monitor_test: table of clamp cases, then ramp, bus, cap and overspeed cases.
// assumes the drive model stands for the motor and the bench plays the safety controller.
`timescale 1ns/1ps
module safe_speed_limit_monitor_test;
  import ssl_pkg::*;
  typedef struct packed {
    logic [4:0] act;
    logic [15:0] rv;
    logic [15:0] er;
    logic [4:0] ei;
  } ssl_row_t;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic rd = 1'b0, wr = 1'b0, ra = 1'b0, rb = 1'b0, ack = 1'b0, use_m = 1'b0, coast = 1'b0;
  logic wreq, indb, vind, torque_off_function, emergency_stop_function, flt;
  logic [6:0] addr = 7'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic signed [15:0] spd_ref = 16'sh0000, bmeas = 16'sh000A;
  logic signed [15:0] meas, ref_o, mspd;
  logic [15:0] ref_u;
  logic [3:1] req = 3'h0;
  logic [3:0] ind;
  ssl_sbus_t sbus = '0;
  int err_count = 0;
  int check_count = 0;
  ssl_row_t rows [8] = '{'{5'h01, 16'h03E8, 16'h0064, 5'h11}, '{5'h10, 16'hFC18, 16'hFF9C, 5'h11},
    '{5'h02, 16'h03E8, 16'h00C8, 5'h02}, '{5'h04, 16'hFC18, 16'hFED4, 5'h04},
    '{5'h08, 16'h03E8, 16'h0190, 5'h08}, '{5'h00, 16'h02BC, 16'h02BC, 5'h00},
    '{5'h00, 16'h03E8, 16'h0320, 5'h00}, '{5'h00, 16'hFC18, 16'hFCE0, 5'h00}};

  assign meas = use_m ? mspd : bmeas;
  assign ref_u = ref_o;
  always #2 clk_in = ~clk_in;

  ssl_monitor #(.MS_CYCLES_P(4)) ssl_monitor_i (
    .clk_in(clk_in), .rstn_in(rstn_in), .address_in(addr), .read_in(rd), .write_in(wr),
    .writedata_in(wdat), .readdata_out(rdat), .waitrequest_out(wreq),
    .speed_meas_in(meas), .speed_ref_in(spd_ref), .speed_ref_out(ref_o),
    .sls1_req_a_in(ra), .sls1_req_b_in(rb), .sls_req_in(req), .sbus_in(sbus),
    .ack_button_input_in(ack), .limit_indication_a_out(ind), .limit_indication_b_out(indb),
    .variable_cap_indication_out(vind), .torque_off_function_out(torque_off_function),
    .emergency_stop_function_out(emergency_stop_function), .fault_event_out(flt));
  ssl_drive_model ssl_drive_model_i (.clk_in(clk_in), .rstn_in(rstn_in), .ref_in(ref_o),
    .sto_in(torque_off_function), .coast_in(coast), .speed_out(mspd));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input int idx, input logic [15:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_in);
    addr <= 7'(idx * 4);
    wr <= w;
    rd <= !w;
    wdat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    if (n >= 50) chk("waitrequest", 32'h0000_0000, {31'h0000_0000, wreq});
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wreg(input int idx, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wreg

  task automatic rchk(input int idx, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 16'h0000, q);
    chk("readdata", e, q);
  endtask : rchk

  initial begin
    repeat (5000) @(posedge clk_in);
    err_count++;
    report_and_stop();
  end

  initial begin
    logic seen;
    int n;
    repeat (5) @(posedge clk_in);
    chk("waitrequest", 32'h0000_0001, {31'h0000_0000, wreq});
    chk("ref_out", 32'h0000_0000, ref_u);
    rstn_in <= 1'b1;
    rchk(IDX_STATUS, 32'h0000_0000);
    wreg(IDX_STATUS, 16'hFFFF);
    rchk(IDX_STATUS, 32'h0000_0000);
    wreg(29, 16'h1234);
    rchk(29, 32'h0000_0000);
    for (int f = 0; f < 5; f++) begin
      n = (f == 4) ? 800 : 100 * (f + 1);
      wreg(4 * f + LIM_NEG, 16'(-n));
      wreg(4 * f + LIM_POS, 16'(n));
      wreg(4 * f + TRIP_NEG, 16'(-n - 100));
      wreg(4 * f + TRIP_POS, 16'(n + 100));
    end
    rchk(1, 32'h0000_0064);
    wreg(IDX_RAMP_ZERO, 16'h0004);
    wreg(IDX_ESTOP_TIME, 16'h0004);
    wreg(IDX_MIN_RAMP, 16'h0001);
    wreg(IDX_MAX_RAMP, 16'h0014);
    wreg(IDX_TIME_DELAY, 16'h0014);
    wreg(IDX_SPD_SCALE, 16'h03E8);
    wreg(IDX_ZERO_SPD, 16'h0014);
    wreg(IDX_CTRL, 16'h400F);
    foreach (rows[i]) begin
      {rb, req, ra} <= rows[i].act;
      spd_ref <= rows[i].rv;
      repeat (4) @(posedge clk_in);
      chk("ref_out", rows[i].er, ref_u);
      chk("indication", rows[i].ei, {indb, ind});
      {rb, req, ra} <= 5'h00;
      repeat (4) @(posedge clk_in);
    end
    // activation above the limit, drive follows the ramp
    use_m <= 1'b1;
    spd_ref <= 16'sh03E8;
    repeat (30) @(posedge clk_in);
    ra <= 1'b1;
    seen = 1'b0;
    repeat (120) begin
      @(posedge clk_in);
      seen = seen | flt;
    end
    chk("fault", 32'h0000_0000, {31'h0000_0000, seen});
    chk("ref_out", 32'h0000_0064, ref_u);
    chk("indication", 32'h0000_0001, {31'h0000_0000, ind[0]});
    ra <= 1'b0;
    repeat (30) @(posedge clk_in);
    // same activation with the motor coasting
    coast <= 1'b1;
    ra <= 1'b1;
    seen = 1'b0;
    for (n = 0; n < 200 && torque_off_function !== 1'b1; n++) begin
      @(posedge clk_in);
      seen = seen | flt;
    end
    chk("fault", 32'h0000_0001, {31'h0000_0000, seen});
    chk("torque_off", 32'h0000_0001, {31'h0000_0000, torque_off_function});
    repeat (2) @(posedge clk_in);
    chk("torque_off", 32'h0000_0001, {31'h0000_0000, torque_off_function});
    chk("indication", 32'h0000_0000, {31'h0000_0000, ind[0]});
    // checked at release: the drive still coasts, so its speed stays inside the safe band
    for (n = 0; n < 100 && torque_off_function !== 1'b0; n++) @(posedge clk_in);
    chk("torque_off", 32'h0000_0000, {31'h0000_0000, torque_off_function});
    chk("indication", 32'h0000_0001, {31'h0000_0000, ind[0]});
    // again in time mode, emergency stop reaction, zero ramp time to zero
    coast <= 1'b0;
    ra <= 1'b0;
    repeat (30) @(posedge clk_in);
    wreg(IDX_RAMP_ZERO, 16'h0000);
    wreg(IDX_TIME_DELAY, 16'h0004);
    wreg(IDX_CTRL, 16'h540F);
    coast <= 1'b1;
    ra <= 1'b1;
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk_in);
      seen = seen | (ref_o <= 16'sh0064);
    end
    chk("ramp_step", 32'h0000_0000, {31'h0000_0000, seen});
    for (n = 0; n < 40 && emergency_stop_function !== 1'b1; n++) @(posedge clk_in);
    chk("emergency_stop", 32'h0000_0001, {31'h0000_0000, emergency_stop_function});
    chk("torque_off", 32'h0000_0000, {31'h0000_0000, torque_off_function});
    coast <= 1'b0;
    ra <= 1'b0;
    use_m <= 1'b0;
    // function 2 and the variable cap from the safety bus
    wreg(IDX_CTRL, 16'h405F);
    req[1] <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk("ref_out", 32'h0000_0320, ref_u);
    sbus.octet3 <= 8'h02;
    repeat (4) @(posedge clk_in);
    chk("ref_out", 32'h0000_00C8, ref_u);
    req[1] <= 1'b0;
    sbus <= '{8'h90, 16'h2000};
    repeat (4) @(posedge clk_in);
    chk("ref_out", 32'h0000_0064, ref_u);
    chk("cap_indication", 32'h0000_0001, {31'h0000_0000, vind});
    spd_ref <= 16'shFC18;
    repeat (4) @(posedge clk_in);
    chk("ref_out", 32'h0000_FE70, ref_u);
    sbus.octet3 <= 8'hD0;
    repeat (4) @(posedge clk_in);
    chk("ref_out", 32'h0000_FF9C, ref_u);
    bmeas <= 16'sh0258;
    repeat (4) @(posedge clk_in);
    chk("torque_off", 32'h0000_0001, {31'h0000_0000, torque_off_function});
    bmeas <= 16'sh000A;
    sbus <= '0;
    repeat (4) @(posedge clk_in);
    chk("ref_out", 32'h0000_FCE0, ref_u);
    chk("cap_indication", 32'h0000_0000, {31'h0000_0000, vind});
    // overspeed trip with manual acknowledge
    wreg(IDX_CTRL, 16'h2800);
    bmeas <= 16'sh03B6;
    repeat (8) @(posedge clk_in);
    chk("emergency_stop", 32'h0000_0001, {31'h0000_0000, emergency_stop_function});
    ack <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("emergency_stop", 32'h0000_0001, {31'h0000_0000, emergency_stop_function});
    ack <= 1'b0;
    bmeas <= 16'sh0000;
    repeat (5) @(posedge clk_in);
    chk("emergency_stop", 32'h0000_0001, {31'h0000_0000, emergency_stop_function});
    ack <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("emergency_stop", 32'h0000_0000, {31'h0000_0000, emergency_stop_function});
    report_and_stop();
  end
endmodule : safe_speed_limit_monitor_test

// ### ssl_channel.sv
// ssl_channel: one limited-speed function with its deceleration supervision.
// assumes limits are ordered neg_trip < neg_lim < pos_lim < pos_trip and tick_in is 1 ms.
`timescale 1ns/1ps
module ssl_channel (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // request and configuration
  input wire logic act_in,
  input wire ssl_pkg::ssl_lim_t lim_in,
  input wire logic signed [15:0] speed_in,
  input wire logic tick_in,
  input wire logic [15:0] step_in,
  input wire logic [15:0] deadline_in,
  input wire logic safe_in,
  // results
  output logic signed [15:0] clamp_neg_out,
  output logic signed [15:0] clamp_pos_out,
  output logic ind_out,
  output logic trip_out
);
  import ssl_pkg::*;

  ssl_ch_st_t st_q, st_d;
  logic signed [15:0] tgt_pos_q, tgt_neg_q, tgt_pos_d, tgt_neg_d, cneg_d, cpos_d;
  logic [15:0] cnt_q;

  wire over_pos = speed_in > lim_in.pos_lim;
  wire over_neg = speed_in < lim_in.neg_lim;
  wire in_win = !over_pos && !over_neg;
  wire past_trip = (speed_in > lim_in.pos_trip) || (speed_in < lim_in.neg_trip);
  wire late = cnt_q >= deadline_in;
  wire signed [15:0] down_pos = ssl_add_sat(tgt_pos_q, -$signed({1'b0, step_in}));
  wire signed [15:0] up_neg = ssl_add_sat(tgt_neg_q, $signed({1'b0, step_in}));
  wire ind_d = ((st_d == CH_ACTIVE) || ((st_d == CH_TRIP) && safe_in)) && in_win;

  always_comb begin
    st_d = st_q;
    case (st_q)
      CH_IDLE: if (act_in) st_d = in_win ? CH_ACTIVE : CH_DECEL;
      // trip limits are not watched while the ramp is followed
      CH_DECEL: begin
        if (!act_in) st_d = CH_IDLE;
        else if (in_win) st_d = CH_ACTIVE;
        else if (late) st_d = CH_TRIP;
      end
      CH_ACTIVE: begin
        if (!act_in) st_d = CH_IDLE;
        else if (past_trip) st_d = CH_TRIP;
      end
      CH_TRIP: if (!act_in) st_d = CH_IDLE;
      default: st_d = CH_IDLE;
    endcase
  end

  always_comb begin
    tgt_pos_d = tgt_pos_q;
    tgt_neg_d = tgt_neg_q;
    if (st_q == CH_IDLE) begin
      tgt_pos_d = over_pos ? speed_in : lim_in.pos_lim;
      tgt_neg_d = over_neg ? speed_in : lim_in.neg_lim;
    end else if (tick_in) begin
      tgt_pos_d = (down_pos < lim_in.pos_lim) ? lim_in.pos_lim : down_pos;
      tgt_neg_d = (up_neg > lim_in.neg_lim) ? lim_in.neg_lim : up_neg;
    end
    case (st_d)
      CH_IDLE: begin
        cneg_d = SPD_MIN;
        cpos_d = SPD_MAX;
      end
      CH_DECEL: begin
        cneg_d = tgt_neg_d;
        cpos_d = tgt_pos_d;
      end
      default: begin
        cneg_d = lim_in.neg_lim;
        cpos_d = lim_in.pos_lim;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= CH_IDLE;
      tgt_pos_q <= SPD_MAX;
      tgt_neg_q <= SPD_MIN;
      cnt_q <= REG_RESET;
      clamp_neg_out <= SPD_MIN;
      clamp_pos_out <= SPD_MAX;
      ind_out <= 1'b0;
      trip_out <= 1'b0;
    end else begin
      st_q <= st_d;
      tgt_pos_q <= tgt_pos_d;
      tgt_neg_q <= tgt_neg_d;
      cnt_q <= (st_q != CH_DECEL) ? REG_RESET : cnt_q + 16'(tick_in && !(&cnt_q));
      clamp_neg_out <= cneg_d;
      clamp_pos_out <= cpos_d;
      ind_out <= ind_d;
      trip_out <= (st_q != CH_TRIP) && (st_d == CH_TRIP);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence decel_late_s;
    (st_q == CH_DECEL) && act_in && !in_win && late;
  endsequence

  clamp_holds_limit_a: assert property ((st_d == CH_ACTIVE) |=>
    (clamp_pos_out == $past(lim_in.pos_lim)) && (clamp_neg_out == $past(lim_in.neg_lim)))
    else $error("clamp does not follow active limit");
  decel_no_trip_a: assert property ((st_q == CH_DECEL) && !late |=> !trip_out)
    else $error("trip raised while ramp still allowed");
  coast_trip_a: assert property (decel_late_s |=> trip_out ##1 !trip_out)
    else $error("coasting not turned into one trip pulse");
  release_clamp_a: assert property ((st_q != CH_IDLE) && !act_in |=>
    !ind_out && (clamp_pos_out == SPD_MAX) && (clamp_neg_out == SPD_MIN))
    else $error("clamp or indication kept after deactivation");
  trip_over_a: assert property ((st_q == CH_ACTIVE) && act_in && past_trip |=>
    trip_out && (st_q == CH_TRIP))
    else $error("trip limit passed without fault");
endmodule : ssl_channel

// ### ssl_drive_model.sv
// ssl_drive_model: drive and motor as the speed supervision block sees them.
// assumes the speed changes by at most one step per clock; torque off runs the motor down.
`timescale 1ns/1ps
module ssl_drive_model #(
  parameter int STEP_P = 64
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // from the block
  input wire logic signed [15:0] ref_in,
  input wire logic sto_in,
  input wire logic coast_in,
  // motor speed
  output logic signed [15:0] speed_out
);
  logic signed [15:0] speed_q;
  logic signed [15:0] speed_d;
  int diff;
  assign diff = (sto_in ? 0 : int'(ref_in)) - int'(speed_q);
  // coasting holds speed unless torque is off: a drive fault leaves the reference unused
  assign speed_d = (coast_in && !sto_in) ? speed_q :
                   (diff > STEP_P) ? speed_q + 16'(STEP_P) :
                   (diff < -STEP_P) ? speed_q - 16'(STEP_P) : speed_q + 16'(diff);
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      speed_q <= 16'sh0000;
    end else begin
      speed_q <= speed_d;
    end
  end
  assign speed_out = speed_q;
endmodule : ssl_drive_model

// ### ssl_monitor.sv
// ssl_monitor: safe speed limit supervision with register file on avalon-mm.
// assumes speed and reference words are synchronous to clk_in and in the same scale.
// Behaviour
// - active limited speed clamps the reference to its limit, or to the ramp target while decelerating
// - indication high only while measured speed sits inside active window
// - deactivation drops indication and releases the clamp to user reference
// - only the first limited speed function has two inputs and two outputs
// - each function keeps negative and positive limits and trip limits beyond them
// - deceleration supervised by ramp times or by a time delay, selectable
// - zero ramp time to zero selects the emergency stop time instead
// - activation above limit ramps down monitored, no trip while ramp followed
// - coasting after activation above limit trips via configured stop reaction
// - after a stop, indication and acknowledgement wait for safe motor state
// - activation comes from a module input or a safety bus request
// - acknowledgement automatic or manual through the acknowledge button
// - third bus byte bit 6 enables negative, bit 7 positive scaling
// - fourth and fifth bus bytes carry the variable scaling value
// - variable cap scales the fourth function's limits as its full scale
// - variable cap indication high only inside the scaled limits
// - max speed supervision version 1 trips to emergency stop beyond trip limit
// - overspeed emergency stop acknowledged only in safe state
// - version 2 clamps the reference to separate negative and positive maxima
// - version 2 also keeps separate trip limits for fault detection
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module ssl_monitor #(
  parameter int MS_CYCLES_P = ssl_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // avalon-mm slave
  input wire logic [ssl_pkg::ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // drive side
  input wire logic signed [15:0] speed_meas_in,
  input wire logic signed [15:0] speed_ref_in,
  output logic signed [15:0] speed_ref_out,
  // activation and acknowledgement
  input wire logic sls1_req_a_in,
  input wire logic sls1_req_b_in,
  input wire logic [ssl_pkg::NUM_SLS-1:1] sls_req_in,
  input wire ssl_pkg::ssl_sbus_t sbus_in,
  input wire logic ack_button_input_in,
  // indications and stop requests
  output logic [ssl_pkg::NUM_SLS-1:0] limit_indication_a_out,
  output logic limit_indication_b_out,
  output logic variable_cap_indication_out,
  output logic torque_off_function_out,
  output logic emergency_stop_function_out,
  output logic fault_event_out
);
  import ssl_pkg::*;

  localparam int PRE_W = (MS_CYCLES_P > 1) ? $clog2(MS_CYCLES_P) : 1;

  logic [15:0] regs_q [0:NREG-1];
  logic wait_q, sto_q, sse_q, fault_q, ack_q, tick_q;
  logic [31:0] rdata_q;
  logic [PRE_W-1:0] pre_q;
  logic signed [15:0] ref_q, lo_c, hi_c;
  logic [15:0] step_q;
  logic [NUM_CH-1:0] ind_w, trip_w;
  logic signed [15:0] cneg_w [0:NUM_CH-1];
  logic signed [15:0] cpos_w [0:NUM_CH-1];
  ssl_lim_t lim_w [0:NUM_CH-1];

  function automatic logic signed [15:0] lim_word(input logic [15:0] w);
    return $signed(w);
  endfunction : lim_word

  function automatic logic signed [15:0] scale_lim(input logic signed [15:0] v,
                                                   input logic [15:0] s, input logic en);
    logic [15:0] sc;
    logic signed [32:0] p;
    sc = (!en || (s > SCALE_FULL)) ? SCALE_FULL : s;
    p = 33'(v) * $signed({17'h0_0000, sc});
    return p[30:15];
  endfunction : scale_lim

  function automatic logic [15:0] abs_spd(input logic signed [15:0] v);
    logic signed [16:0] w;
    w = 17'(v);
    return (v < 0) ? 16'(-w) : 16'(w);
  endfunction : abs_spd

  // register bus decode
  wire [4:0] idx = address_in[6:2];
  wire take = (read_in || write_in) && !wait_q;
  wire wr_hit = take && write_in && (int'(idx) < NREG);
  wire [15:0] ctrl = regs_q[IDX_CTRL];
  wire method_time = ctrl[CTRL_METHOD_TIME];
  wire ack_manual = ctrl[CTRL_ACK_MANUAL];
  wire stop_sse = ctrl[CTRL_STOP_SSE];
  wire [1:0] sms_ver = ctrl[CTRL_SMS_LSB +: 2];
  wire [NUM_CH-1:0] fn_en = ctrl[CTRL_EN_LSB +: NUM_CH];
  wire [NUM_CH-1:0] src_bus = ctrl[CTRL_SRC_LSB +: NUM_CH];
  wire safe = abs_spd(speed_meas_in) <= regs_q[IDX_ZERO_SPD];

  // activation sources; sls1 alone has a second input
  wire [NUM_SLS-1:0] pin_req = {sls_req_in, sls1_req_a_in || sls1_req_b_in};
  wire [NUM_CH-1:0] bus_req = sbus_in.octet3[OCT3_ACT_LSB +: NUM_CH];
  wire [NUM_CH-1:0] pin_req_x = {1'b0, pin_req};
  wire [NUM_CH-1:0] src_eff = src_bus | (NUM_CH'(1) << VAR_CH);
  wire [NUM_CH-1:0] act = fn_en & ((src_eff & bus_req) | (~src_eff & pin_req_x));

  // deceleration ramp and supervision deadline
  wire [15:0] ramp0 = regs_q[IDX_RAMP_ZERO];
  wire [15:0] ramp_sel = (ramp0 == RAMP_ZERO_MS) ? regs_q[IDX_ESTOP_TIME] : ramp0;
  // ramp mode never commands a ramp steeper than the shortest allowed time
  wire [15:0] ramp_eff = (!method_time && (ramp_sel < regs_q[IDX_MIN_RAMP])) ?
                         regs_q[IDX_MIN_RAMP] : ramp_sel;
  wire [15:0] deadline = method_time ? regs_q[IDX_TIME_DELAY] : regs_q[IDX_MAX_RAMP];
  // one divider shared by all channels; result lags a config write by a cycle
  wire [15:0] step_d = (ramp_eff == 16'h0000) ? 16'hFFFF : regs_q[IDX_SPD_SCALE] / ramp_eff;

  // max speed supervision
  wire signed [15:0] sms_neg = lim_word(regs_q[IDX_SMS_BASE + LIM_NEG]);
  wire signed [15:0] sms_pos = lim_word(regs_q[IDX_SMS_BASE + LIM_POS]);
  wire signed [15:0] sms_tneg = lim_word(regs_q[IDX_SMS_BASE + TRIP_NEG]);
  wire signed [15:0] sms_tpos = lim_word(regs_q[IDX_SMS_BASE + TRIP_POS]);
  wire sms_on = (sms_ver == SMS_V1) || (sms_ver == SMS_V2);
  wire sms_trip = sms_on && ((speed_meas_in > sms_tpos) || (speed_meas_in < sms_tneg));
  wire sms_clamp = sms_ver == SMS_V2;

  // stop reactions and acknowledgement
  wire ack_rise = ack_button_input_in && !ack_q;
  wire ack_ok = safe && (ack_manual ? ack_rise : 1'b1);
  wire ch_trip = |trip_w;
  wire sto_set = ch_trip && !stop_sse;
  wire sse_set = (ch_trip && stop_sse) || sms_trip;
  wire sto_d = sto_set || (sto_q && !ack_ok);
  wire sse_d = sse_set || (sse_q && !ack_ok);

  wire [15:0] status = 16'((ind_w << ST_IND_LSB) | (act << ST_ACT_LSB) |
                           (sto_q << ST_STO) | (sse_q << ST_SSE) | (safe << ST_SAFE));
  wire [15:0] rd_word = (int'(idx) < NREG) ? regs_q[idx] :
                        (int'(idx) == IDX_STATUS) ? status : 16'h0000;

  // limit sets; the variable cap rides on the fourth function's values
  genvar g;
  generate
    for (g = 0; g < NUM_SLS; g++) begin : g_lim
      assign lim_w[g].neg_lim = lim_word(regs_q[IDX_LIM_BASE + 4 * g + LIM_NEG]);
      assign lim_w[g].pos_lim = lim_word(regs_q[IDX_LIM_BASE + 4 * g + LIM_POS]);
      assign lim_w[g].neg_trip = lim_word(regs_q[IDX_LIM_BASE + 4 * g + TRIP_NEG]);
      assign lim_w[g].pos_trip = lim_word(regs_q[IDX_LIM_BASE + 4 * g + TRIP_POS]);
    end
  endgenerate

  assign lim_w[VAR_CH].neg_lim = scale_lim(lim_w[NUM_SLS-1].neg_lim, sbus_in.scale,
                                           sbus_in.octet3[OCT3_NEG_SCALE]);
  assign lim_w[VAR_CH].pos_lim = scale_lim(lim_w[NUM_SLS-1].pos_lim, sbus_in.scale,
                                           sbus_in.octet3[OCT3_POS_SCALE]);
  assign lim_w[VAR_CH].neg_trip = lim_w[NUM_SLS-1].neg_trip;
  assign lim_w[VAR_CH].pos_trip = lim_w[NUM_SLS-1].pos_trip;

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      ssl_channel u_ch (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .act_in(act[g]),
        .lim_in(lim_w[g]),
        .speed_in(speed_meas_in),
        .tick_in(tick_q),
        .step_in(step_q),
        .deadline_in(deadline),
        .safe_in(safe),
        .clamp_neg_out(cneg_w[g]),
        .clamp_pos_out(cpos_w[g]),
        .ind_out(ind_w[g]),
        .trip_out(trip_w[g])
      );
    end
  endgenerate

  // tightest bound over all active clamps
  always_comb begin
    lo_c = sms_clamp ? sms_neg : SPD_MIN;
    hi_c = sms_clamp ? sms_pos : SPD_MAX;
    for (int i = 0; i < NUM_CH; i++) begin
      if (cneg_w[i] > lo_c) lo_c = cneg_w[i];
      if (cpos_w[i] < hi_c) hi_c = cpos_w[i];
    end
  end

  wire signed [15:0] ref_d = (speed_ref_in > hi_c) ? hi_c :
                             (speed_ref_in < lo_c) ? lo_c : speed_ref_in;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NREG; i++) regs_q[i] <= REG_RESET;
    end else if (wr_hit) begin
      regs_q[idx] <= writedata_in[15:0];
    end
  end

  // one wait cycle per access, then a single-cycle answer
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !((read_in || write_in) && wait_q);
      if ((read_in || write_in) && wait_q) rdata_q <= {16'h0000, rd_word};
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre_q <= '0;
      tick_q <= 1'b0;
      step_q <= 16'h0000;
    end else begin
      tick_q <= pre_q == PRE_W'(MS_CYCLES_P - 1);
      pre_q <= (pre_q == PRE_W'(MS_CYCLES_P - 1)) ? '0 : pre_q + 1'b1;
      step_q <= step_d;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_q <= 16'sh0000;
      sto_q <= 1'b0;
      sse_q <= 1'b0;
      fault_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      sto_q <= sto_d;
      sse_q <= sse_d;
      fault_q <= ch_trip || (sms_trip && !sse_q);
      ack_q <= ack_button_input_in;
    end
  end

  assign readdata_out = rdata_q;
  assign waitrequest_out = wait_q;
  assign speed_ref_out = ref_q;
  assign limit_indication_a_out = ind_w[NUM_SLS-1:0];
  assign limit_indication_b_out = ind_w[0];
  assign variable_cap_indication_out = ind_w[VAR_CH];
  assign torque_off_function_out = sto_q;
  assign emergency_stop_function_out = sse_q;
  assign fault_event_out = fault_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sms_trip_sse_a: assert property (sms_trip |=> sse_q)
    else $error("overspeed did not raise emergency stop");
  sse_ack_safe_a: assert property ($fell(sse_q) |-> $past(safe))
    else $error("emergency stop released outside safe state");
  sto_ack_safe_a: assert property ($fell(sto_q) |-> $past(safe) &&
    (!$past(ack_manual) || $past(ack_rise)))
    else $error("torque off released without proper acknowledgement");
  sms_clamp_a: assert property (sms_clamp |=> speed_ref_out <= $past(sms_pos) &&
    speed_ref_out >= $past(sms_neg) || $past(sms_neg) > $past(sms_pos))
    else $error("reference passed the maximum speed limit");
  var_ind_scaled_a: assert property (variable_cap_indication_out |->
    $past(speed_meas_in) <= $past(lim_w[VAR_CH].pos_lim) &&
    $past(speed_meas_in) >= $past(lim_w[VAR_CH].neg_lim))
    else $error("variable cap indication outside scaled limits");
  bus_answer_a: assert property ((read_in || write_in) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer not one cycle after request");
endmodule : ssl_monitor

// ### ssl_pkg.sv
// ssl_pkg: constants, register map and carrier types for the speed supervision block.
// assumes a single 250 MHz clock domain and signed 16-bit speed words.
package ssl_pkg;
  localparam int SPD_W = 16;
  localparam int NUM_SLS = 4;
  localparam int NUM_CH = 5;
  localparam int VAR_CH = 4;
  localparam int NREG = 28;
  localparam int ADDR_W = 7;
  // word indices; byte address is index times four
  localparam int IDX_LIM_BASE = 0;
  localparam int IDX_SMS_BASE = 16;
  localparam int IDX_CTRL = 20;
  localparam int IDX_RAMP_ZERO = 21;
  localparam int IDX_ESTOP_TIME = 22;
  localparam int IDX_MIN_RAMP = 23;
  localparam int IDX_MAX_RAMP = 24;
  localparam int IDX_TIME_DELAY = 25;
  localparam int IDX_SPD_SCALE = 26;
  localparam int IDX_ZERO_SPD = 27;
  localparam int IDX_STATUS = 28;
  // offsets inside one group of four limit words
  localparam int LIM_NEG = 0;
  localparam int LIM_POS = 1;
  localparam int TRIP_NEG = 2;
  localparam int TRIP_POS = 3;
  // control word fields
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_SRC_LSB = 5;
  localparam int CTRL_METHOD_TIME = 10;
  localparam int CTRL_ACK_MANUAL = 11;
  localparam int CTRL_STOP_SSE = 12;
  localparam int CTRL_SMS_LSB = 13;
  localparam logic [1:0] SMS_V1 = 2'h1;
  localparam logic [1:0] SMS_V2 = 2'h2;
  // status word fields
  localparam int ST_IND_LSB = 0;
  localparam int ST_ACT_LSB = 5;
  localparam int ST_STO = 10;
  localparam int ST_SSE = 11;
  localparam int ST_SAFE = 12;
  // safety bus message fields
  localparam int OCT3_ACT_LSB = 0;
  localparam int OCT3_NEG_SCALE = 6;
  localparam int OCT3_POS_SCALE = 7;
  localparam logic [15:0] SCALE_FULL = 16'h8000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] RAMP_ZERO_MS = 16'h0000;
  localparam logic signed [15:0] SPD_MAX = 16'sh7FFF;
  localparam logic signed [15:0] SPD_MIN = -16'sh7FFF - 16'sh0001;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    CH_IDLE = 4'b0001,
    CH_DECEL = 4'b0010,
    CH_ACTIVE = 4'b0100,
    CH_TRIP = 4'b1000
  } ssl_ch_st_t;

  typedef struct packed {
    logic signed [15:0] neg_lim;
    logic signed [15:0] pos_lim;
    logic signed [15:0] neg_trip;
    logic signed [15:0] pos_trip;
  } ssl_lim_t;

  typedef struct packed {
    logic [7:0] octet3;
    logic [15:0] scale;
  } ssl_sbus_t;

  function automatic logic signed [15:0] ssl_add_sat(input logic signed [15:0] a,
                                                       input logic signed [16:0] b);
    logic signed [17:0] s;
    s = 18'(a) + 18'(b);
    if (s > 18'(SPD_MAX)) return SPD_MAX;
    if (s < 18'(SPD_MIN)) return SPD_MIN;
    return s[15:0];
  endfunction : ssl_add_sat
endpackage : ssl_pkg
